// ### design/fpe_top.sv
// Program and erase command sequencer of a serial NOR flash
`timescale 1ns/10ps
`include "fpe_params.svh"
// Summary of operation
// - Data past page end wraps to start
// - Over 256 bytes keeps last 256
// - Unsent bytes of page stay unchanged
// - Program ends only on byte boundary
// - Program cycle starts, busy until done
// - Write latch cleared before cycle ends
// - Protected page program is refused
// - Erase ends right after address bytes
// - Erase cycle starts, busy until done
// - Protected sector erase is ignored
// - Protected block erase is refused
module fpe_top
#(
  parameter int unsigned PROG_CYC = `FPE_PROG_TIME_US * `FPE_CLK_MHZ,
  parameter int unsigned SECT_CYC = `FPE_SECT_TIME_US * `FPE_CLK_MHZ,
  parameter int unsigned BLK32_CYC = `FPE_BLK32_TIME_US * `FPE_CLK_MHZ,
  parameter int unsigned BLK64_CYC = `FPE_BLK64_TIME_US * `FPE_CLK_MHZ
)
(
  // System clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] data_lane_i,
  // Status bits
  input wire logic write_latch_bit_i,
  input wire logic quad_lane_enable_i,
  input wire logic [4:0] block_protect_bits_i,
  output logic op_in_progress_flag_o,
  output logic write_latch_clr_o,
  // Array operation port
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output fpe_pkg::fpe_mem_op_type mem_op_o
);
  // ****************************************
  // Link domain
  // ****************************************
  logic fresh_q;
  logic frame_tog_q;
  logic [2:0] bit_q;
  logic [2:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] opc_q;
  logic [7:0] ptr_q;
  logic [23:0] addr_q;
  logic [1:0] qe_s_q;
  logic [1:0] lock_s_q;
  logic valid_q [`FPE_PAGE_ENTRIES];
  logic [7:0] pbuf_q [`FPE_PAGE_ENTRIES];
  logic lock_q;
  wire logic [2:0] cur_bit;
  wire logic [2:0] cur_cnt;
  wire logic quad_now;
  wire logic [3:0] bit_sum;
  wire logic byte_done;
  wire logic [7:0] sr_d;
  wire logic addr_phase;
  wire logic wr_en;
  wire logic clr_en;

  // frame start
  // The link clock stops between frames, so the frame's own select marks a new one;
  // reset sets it too, or the first frame after power-up could start misaligned
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fresh_q <= 1'b1;
    else if (cs_n_i)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  assign cur_bit = fresh_q ? `FPE_BIT_ZERO : bit_q;
  assign cur_cnt = fresh_q ? `FPE_CNT_START : cnt_q;
  assign quad_now = (cur_cnt != `FPE_CNT_START) && (opc_q == `FPE_OP_QPROG) && qe_s_q[1];
  assign bit_sum = {1'b0, cur_bit} + (quad_now ? `FPE_STEP_QUAD : `FPE_STEP_ONE);
  assign byte_done = (bit_sum == `FPE_BYTE_BITS);
  assign sr_d = quad_now ? {sr_q[3:0], data_lane_i} : {sr_q[6:0], data_lane_i[0]};
  assign addr_phase = (cur_cnt != `FPE_CNT_START) && (cur_cnt < `FPE_CNT_ADDR_DONE);
  assign wr_en = byte_done && (cur_cnt >= `FPE_CNT_ADDR_DONE) && !lock_s_q[1];
  assign clr_en = fresh_q && !lock_s_q[1];

  // Crossings into the link domain; reset only while the link is idle
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      qe_s_q <= 2'h0;
      lock_s_q <= 2'h0;
      frame_tog_q <= 1'b0;
    end
    else
    begin
      qe_s_q <= {qe_s_q[0], quad_lane_enable_i};
      lock_s_q <= {lock_s_q[0], lock_q};
      frame_tog_q <= frame_tog_q ^ fresh_q;
    end
  end

  always_ff @(posedge sclk_i)
  begin
    sr_q <= sr_d;
    bit_q <= bit_sum[2:0];
    if (byte_done && (cur_cnt != `FPE_CNT_DATA_DONE))
      cnt_q <= cur_cnt + `FPE_CNT_ONE;
    else
      cnt_q <= cur_cnt;
  end

  always_ff @(posedge sclk_i)
  begin
    if (byte_done && (cur_cnt == `FPE_CNT_START))
      opc_q <= sr_d;
    if (byte_done && addr_phase)
      addr_q <= {addr_q[15:0], sr_d};
  end

  always_ff @(posedge sclk_i)
  begin
    if (byte_done && (cur_cnt == `FPE_CNT_ADDR_LAST))
      ptr_q <= sr_d;
    else if (wr_en)
      ptr_q <= ptr_q + `FPE_IDX_ONE;
  end

  for (genvar i = 0; i < `FPE_PAGE_ENTRIES; i++)
  begin : g_ent
    always_ff @(posedge sclk_i)
    begin
      if (wr_en && (ptr_q == 8'(i)))
      begin
        pbuf_q[i] <= sr_d;
        valid_q[i] <= 1'b1;
      end
      else if (clr_en)
        valid_q[i] <= 1'b0;
    end
  end

  // ****************************************
  // System domain
  // ****************************************
  fpe_pkg::fpe_state_type st_q;
  fpe_pkg::fpe_kind_type kind_q;
  logic cs_n_d1_q;
  logic seen_tog_q;
  logic wl_clr_q;
  logic [7:0] idx_q;
  logic [23:0] op_addr_q;
  logic [31:0] tmr_q;
  wire logic cs_n_s;
  wire logic cs_rise;
  wire logic new_frame;
  wire logic is_prog;
  wire logic is_erase;
  wire logic prog_ok;
  wire logic erase_ok;
  wire logic [3:0] bpn;
  wire logic [8:0] blk;
  wire logic [8:0] pspan;
  wire logic prot_hit;
  wire logic start_ok;
  wire fpe_pkg::fpe_kind_type kind_d;
  wire logic buf_in_valid;
  wire logic buf_in_ready;
  wire fpe_pkg::fpe_mem_op_type buf_in;
  wire logic push;
  wire logic walk_step;
  wire logic [31:0] erase_load;

  fpe_sync #(.RST_VAL(1'b1)) u_cs_sync
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(cs_n_i),
    .q_o(cs_n_s)
  );

  // Link registers stand still once select is high, so they are read as is
  assign cs_rise = cs_n_s && !cs_n_d1_q;
  assign new_frame = (frame_tog_q != seen_tog_q);
  // quad program only with quad enable
  assign is_prog = (opc_q == `FPE_OP_PROG) || ((opc_q == `FPE_OP_QPROG) && quad_lane_enable_i);
  assign is_erase = (opc_q == `FPE_OP_SECT) || (opc_q == `FPE_OP_BLK32) ||
                    (opc_q == `FPE_OP_BLK64);
  assign prog_ok = is_prog && (cnt_q == `FPE_CNT_DATA_DONE) && (bit_q == `FPE_BIT_ZERO);
  assign erase_ok = is_erase && (cnt_q == `FPE_CNT_ADDR_DONE) && (bit_q == `FPE_BIT_ZERO);
  assign kind_d = (opc_q == `FPE_OP_SECT) ? fpe_pkg::FPE_K_SECT :
                  (opc_q == `FPE_OP_BLK32) ? fpe_pkg::FPE_K_BLK32 :
                  (opc_q == `FPE_OP_BLK64) ? fpe_pkg::FPE_K_BLK64 : fpe_pkg::FPE_K_PROG;

  // protected span of 64KB blocks, top or bottom
  assign bpn = block_protect_bits_i[3:0];
  assign blk = {1'b0, addr_q[`FPE_BLK_SEL]};
  assign pspan = (bpn == `FPE_PROT_NONE) ? 9'h000 :
                 (bpn >= `FPE_PROT_FULL) ? `FPE_BLK_COUNT :
                 (`FPE_SPAN_ONE << (bpn - `FPE_PROT_ONE));
  assign prot_hit = block_protect_bits_i[4] ? (blk < pspan) : (blk >= (`FPE_BLK_COUNT - pspan));

  assign start_ok = cs_rise && new_frame && (st_q == fpe_pkg::ST_IDLE) &&
                    write_latch_bit_i && !prot_hit && (prog_ok || erase_ok);

  // only valid entries reach the array
  assign buf_in_valid = ((st_q == fpe_pkg::ST_WALK) && valid_q[idx_q]) ||
                        (st_q == fpe_pkg::ST_ISSUE);
  assign buf_in.kind = kind_q;
  assign buf_in.addr = (st_q == fpe_pkg::ST_WALK) ? {op_addr_q[`FPE_PAGE_SEL], idx_q} : op_addr_q;
  assign buf_in.data = (st_q == fpe_pkg::ST_WALK) ? pbuf_q[idx_q] : `FPE_FILL_BYTE;
  assign push = buf_in_valid && buf_in_ready;
  assign walk_step = (st_q == fpe_pkg::ST_WALK) && (!valid_q[idx_q] || buf_in_ready);
  assign erase_load = (kind_q == fpe_pkg::FPE_K_SECT) ? 32'(SECT_CYC - 1) :
                      (kind_q == fpe_pkg::FPE_K_BLK32) ? 32'(BLK32_CYC - 1) :
                      32'(BLK64_CYC - 1);

  fpe_buf2 u_buf
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in),
    .out_valid_o(mem_valid_o),
    .out_ready_i(mem_ready_i),
    .out_data_o(mem_op_o)
  );

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_d1_q <= 1'b1;
      seen_tog_q <= 1'b0;
      wl_clr_q <= 1'b0;
    end
    else
    begin
      cs_n_d1_q <= cs_n_s;
      if (cs_rise)
        seen_tog_q <= frame_tog_q;
      wl_clr_q <= start_ok;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= fpe_pkg::ST_IDLE;
      kind_q <= fpe_pkg::FPE_K_PROG;
      op_addr_q <= 24'h00_0000;
      idx_q <= `FPE_IDX_FIRST;
      tmr_q <= `FPE_TMR_ZERO;
      lock_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        fpe_pkg::ST_IDLE:
        begin
          if (start_ok)
          begin
            kind_q <= kind_d;
            op_addr_q <= addr_q;
            idx_q <= `FPE_IDX_FIRST;
            lock_q <= prog_ok;
            st_q <= prog_ok ? fpe_pkg::ST_WALK : fpe_pkg::ST_ISSUE;
          end
        end
        fpe_pkg::ST_WALK:
        begin
          if (walk_step)
          begin
            idx_q <= idx_q + `FPE_IDX_ONE;
            if (idx_q == `FPE_IDX_LAST)
            begin
              lock_q <= 1'b0;
              tmr_q <= 32'(PROG_CYC - 1);
              st_q <= fpe_pkg::ST_WAIT;
            end
          end
        end
        fpe_pkg::ST_ISSUE:
        begin
          if (push)
          begin
            tmr_q <= erase_load;
            st_q <= fpe_pkg::ST_WAIT;
          end
        end
        fpe_pkg::ST_WAIT:
        begin
          if (tmr_q == `FPE_TMR_ZERO)
            st_q <= fpe_pkg::ST_IDLE;
          else
            tmr_q <= tmr_q - `FPE_TMR_ONE;
        end
      endcase
    end
  end

  assign op_in_progress_flag_o = (st_q != fpe_pkg::ST_IDLE);
  assign write_latch_clr_o = wl_clr_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_prog_busy;
    start_ok && prog_ok |=> op_in_progress_flag_o [*3];
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy not raised by program");

  property p_wait_end;
    (st_q == fpe_pkg::ST_WAIT) && (tmr_q == `FPE_TMR_ZERO) |=> !op_in_progress_flag_o;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("busy held past cycle end");

  property p_latch_clr;
    start_ok |=> write_latch_clr_o ##1 !write_latch_clr_o;
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("write latch not cleared");

  property p_align;
    cs_rise && (bit_q != `FPE_BIT_ZERO) |-> !start_ok;
  endproperty
  a_align: assert property (p_align) else $error("misaligned command started");

  property p_prot;
    cs_rise && prot_hit |=> !op_in_progress_flag_o || $past(op_in_progress_flag_o);
  endproperty
  a_prot: assert property (p_prot) else $error("protected target executed");

  property p_erase_len;
    cs_rise && is_erase &&
      ((cnt_q != `FPE_CNT_ADDR_DONE) || (bit_q != `FPE_BIT_ZERO)) |-> !start_ok;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

  property p_erase_busy;
    start_ok && erase_ok |=> op_in_progress_flag_o [*4];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("busy not raised by erase");

  property p_no_latch;
    cs_rise && !write_latch_bit_i |-> !start_ok;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("started without latch");

  property p_page;
    mem_valid_o && (mem_op_o.kind == fpe_pkg::FPE_K_PROG) |->
      (mem_op_o.addr[`FPE_PAGE_SEL] == op_addr_q[`FPE_PAGE_SEL]);
  endproperty
  a_page: assert property (p_page) else $error("program left its page");

  property p_skip;
    (st_q == fpe_pkg::ST_WALK) && !valid_q[idx_q] |-> !buf_in_valid ##1 !$stable(idx_q);
  endproperty
  a_skip: assert property (p_skip) else $error("unsent byte programmed");

  c_prog: cover property (start_ok && prog_ok);
  c_erase: cover property (start_ok && erase_ok);
  c_refused: cover property (cs_rise && new_frame && !start_ok);
  c_stall: cover property (mem_valid_o && !mem_ready_i && !buf_in_ready);
endmodule

// ### inc/fpe_params.svh
// Constants for the flash program and erase sequencer
`ifndef FPE_PARAMS_SVH
`define FPE_PARAMS_SVH
// ****************************************
// Opcodes
// ****************************************
`define FPE_OP_PROG 8'h02
`define FPE_OP_QPROG 8'h32
`define FPE_OP_SECT 8'h20
`define FPE_OP_BLK32 8'h52
`define FPE_OP_BLK64 8'hd8
// ****************************************
// Timing
// ****************************************
`define FPE_CLK_MHZ 20
`define FPE_PROG_TIME_US 600
`define FPE_SECT_TIME_US 50000
`define FPE_BLK32_TIME_US 150000
`define FPE_BLK64_TIME_US 250000
// ****************************************
// Frame counters and fields
// ****************************************
`define FPE_CNT_START 3'h0
`define FPE_CNT_ADDR_LAST 3'h3
`define FPE_CNT_ADDR_DONE 3'h4
`define FPE_CNT_DATA_DONE 3'h5
`define FPE_CNT_ONE 3'h1
`define FPE_BIT_ZERO 3'h0
`define FPE_BYTE_BITS 4'h8
`define FPE_STEP_QUAD 4'h4
`define FPE_STEP_ONE 4'h1
`define FPE_BLK_SEL 23:16
`define FPE_PAGE_SEL 23:8
`define FPE_IDX_FIRST 8'h00
`define FPE_IDX_LAST 8'hff
`define FPE_IDX_ONE 8'h01
`define FPE_PAGE_ENTRIES 256
`define FPE_PROT_NONE 4'h0
`define FPE_PROT_FULL 4'h9
`define FPE_PROT_ONE 4'h1
`define FPE_BLK_COUNT 9'h100
`define FPE_SPAN_ONE 9'h001
`define FPE_TMR_ZERO 32'h0000_0000
`define FPE_TMR_ONE 32'h0000_0001
`define FPE_FILL_BYTE 8'h00
`endif

// ### inc/fpe_pkg.sv
// Types shared by the flash program and erase sequencer
package fpe_pkg;
  typedef enum logic [1:0] {FPE_K_PROG, FPE_K_SECT, FPE_K_BLK32, FPE_K_BLK64} fpe_kind_type;
  typedef struct packed
  {
    fpe_kind_type kind;
    logic [23:0] addr;
    logic [7:0] data;
  } fpe_mem_op_type;
  typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_ISSUE, ST_WAIT} fpe_state_type;
endpackage

// ### design/fpe_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module fpe_sync
#(
  parameter logic RST_VAL = 1'b0
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Level in and out
  input wire logic d_i,
  output logic q_o
);
  logic [2:0] stage_q;
  logic q_q;

  // Output moves only once the second and third stages agree
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      stage_q <= {3{RST_VAL}};
      q_q <= RST_VAL;
    end
    else
    begin
      stage_q <= {stage_q[1:0], d_i};
      if (stage_q[1] == stage_q[2])
        q_q <= stage_q[2];
    end
  end

  assign q_o = q_q;
endmodule

// ### design/fpe_buf2.sv
// Two-entry valid/ready buffer for array operations
`timescale 1ns/10ps
module fpe_buf2
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input fpe_pkg::fpe_mem_op_type in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output fpe_pkg::fpe_mem_op_type out_data_o
);
  fpe_pkg::fpe_mem_op_type slot_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  wire logic push;
  wire logic pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = slot_q[rd_q];

  always_ff @(posedge clock_i)
  begin
    if (push)
      slot_q[wr_q] <= in_data_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      wr_q <= wr_q ^ push;
      rd_q <= rd_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### test/fpe_host_model.sv
// Host flash controller model driving the serial link of the sequencer
`timescale 1ns/10ps
module fpe_host_model
(
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] data_lane_o
);
  // Half of the 6 ns link clock; the clock stands low outside frames
  localparam realtime HALF = 3.0;
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    data_lane_o = 4'h5;
  end
  task automatic tick(input logic [3:0] v);
    data_lane_o = v;
    #(HALF);
    sclk_o = 1'b1;
    #(HALF);
    sclk_o = 1'b0;
  endtask
  // Lanes 1-3 carry no data in single-lane phases, so they are inverted each tick to churn
  task automatic bit1(input logic b);
    tick({~data_lane_o[3:1], b});
  endtask
  // ****************************************
  // One command frame; data byte k is k ^ op, bit 7 flipped past 256
  // ****************************************
  task automatic send_frame(input logic [7:0] op, input logic [23:0] addr, input int n,
                            input logic quad, input int extra);
    logic [7:0] d;
    #(HALF);
    cs_n_o = 1'b0;
    for (int i = 7; i >= 0; i--)
      bit1(op[i]);
    for (int i = (quad ? 5 : 23); i >= 0; i--)
      if (quad)
        tick(addr[i*4 +: 4]);
      else
        bit1(addr[i]);
    for (int k = 0; k < n; k++)
    begin
      d = 8'(k) ^ op ^ ((k >= 256) ? 8'h80 : 8'h00);
      for (int i = (quad ? 1 : 7); i >= 0; i--)
        if (quad)
          tick(d[i*4 +: 4]);
        else
          bit1(d[i]);
    end
    for (int k = 0; k < extra; k++)
      bit1(1'b1);
    #(HALF);
    cs_n_o = 1'b1;
    data_lane_o = ~data_lane_o;
    // Select must stay high for at least 300 ns between frames
    #400;
  endtask
endmodule

// ### test/test_flash_program_erase_commands.sv
// Self-checking testbench of the program and erase sequencer
`timescale 1ns/10ps
module test_flash_program_erase_commands;
  logic clock_i;
  logic rst_n_i;
  logic sclk;
  logic cs_n;
  logic [3:0] lanes;
  logic wlatch;
  logic qen;
  logic [4:0] prot;
  logic busy;
  logic clr;
  logic mem_valid;
  logic mem_ready;
  fpe_pkg::fpe_mem_op_type mem_op;
  logic [33:0] got[$];
  logic [7:0] ers[3] = '{8'h20, 8'h52, 8'hd8};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int busy_cyc;
  int clr_cnt;
  always #25 clock_i = ~clock_i;
  fpe_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .data_lane_o(lanes));
  // Short cycle counts keep the run brief
  fpe_top #(.PROG_CYC(20), .SECT_CYC(40), .BLK32_CYC(60), .BLK64_CYC(80)) u_dut
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sclk_i(sclk),
    .cs_n_i(cs_n),
    .data_lane_i(lanes),
    .write_latch_bit_i(wlatch),
    .quad_lane_enable_i(qen),
    .block_protect_bits_i(prot),
    .op_in_progress_flag_o(busy),
    .write_latch_clr_o(clr),
    .mem_valid_o(mem_valid),
    .mem_ready_i(mem_ready),
    .mem_op_o(mem_op)
  );
  // ****************************************
  // Array side: stalls 8 of every 32 cycles so the buffer fills
  // ****************************************
  always @(posedge clock_i)
  begin
    cyc++;
    if (mem_valid === 1'b1 && mem_ready === 1'b1 && rst_n_i === 1'b1)
      got.push_back(mem_op);
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end
  always @(negedge clock_i)
  begin
    mem_ready <= (cyc[4:3] != 2'h0);
    busy_cyc += (busy === 1'b1);
    clr_cnt += (clr === 1'b1);
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // One frame, then the outcome: ops, busy length, latch clear
  // ****************************************
  task automatic run(input logic [7:0] op, input logic [23:0] addr, input int n,
                     input logic quad, input int extra, input logic ok);
    logic e_v[256];
    logic [7:0] e_d[256];
    int off;
    int j;
    int cyc_min;
    fpe_pkg::fpe_kind_type k;
    got.delete();
    busy_cyc = 0;
    clr_cnt = 0;
    u_host.send_frame(op, addr, n, quad, extra);
    for (int i = 0; i < 20 && busy !== 1'b1; i++)
      @(negedge clock_i);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(negedge clock_i);
    repeat (4) @(negedge clock_i);
    chk(busy, 1'b0);
    k = (op == 8'h20) ? fpe_pkg::FPE_K_SECT : (op == 8'h52) ? fpe_pkg::FPE_K_BLK32 :
        (op == 8'hd8) ? fpe_pkg::FPE_K_BLK64 : fpe_pkg::FPE_K_PROG;
    cyc_min = (k == fpe_pkg::FPE_K_PROG) ? 20 : 20 * (int'(k) + 1);
    if (!ok)
    begin
      chk(busy_cyc + clr_cnt + got.size(), 0);
      return;
    end
    chk(clr_cnt, 1);
    chk(busy_cyc >= cyc_min, 1'b1);
    if (k != fpe_pkg::FPE_K_PROG)
    begin
      chk(got.size(), 1);
      chk(got[0], {k, addr, 8'h00});
      return;
    end
    for (int i = 0; i < 256; i++)
      e_v[i] = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      off = (addr[7:0] + i) % 256;
      e_v[off] = 1'b1;
      e_d[off] = 8'(i) ^ op ^ ((i >= 256) ? 8'h80 : 8'h00);
    end
    j = 0;
    for (int i = 0; i < 256; i++)
      if (e_v[i] && j < got.size())
      begin
        chk(got[j], {fpe_pkg::FPE_K_PROG, addr[23:8], 8'(i), e_d[i]});
        j++;
      end
      else if (e_v[i])
        j++;
    chk(got.size(), j);
  endtask
  initial
  begin
    clock_i = 1'b0;
    // A real falling edge, so the link-side flops see their reset
    rst_n_i = 1'b1;
    #1;
    rst_n_i = 1'b0;
    wlatch = 1'b1;
    qen = 1'b1;
    prot = 5'h00;
    mem_ready = 1'b1;
    repeat (8) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    run(8'h02, 24'h0012fe, 3, 1'b0, 0, 1'b1);
    run(8'h02, 24'h003400, 258, 1'b0, 0, 1'b1);
    run(8'h02, 24'h003400, 2, 1'b0, 3, 1'b0);
    run(8'h32, 24'h005633, 2, 1'b1, 0, 1'b1);
    qen = 1'b0;
    run(8'h32, 24'h005633, 2, 1'b1, 0, 1'b0);
    qen = 1'b1;
    wlatch = 1'b0;
    run(8'h02, 24'h000010, 1, 1'b0, 0, 1'b0);
    wlatch = 1'b1;
    prot = 5'h01;
    run(8'h02, 24'hff0100, 1, 1'b0, 0, 1'b0);
    foreach (ers[i])
    begin
      run(ers[i], 24'hfe1234, 0, 1'b0, 0, 1'b1);
      run(ers[i], 24'hff4321, 0, 1'b0, 0, 1'b0);
    end
    prot = 5'h11;
    run(8'h52, 24'h00ab00, 0, 1'b0, 0, 1'b0);
    run(8'h02, 24'h010000, 1, 1'b0, 0, 1'b1);
    prot = 5'h09;
    run(8'h20, 24'h7f0000, 0, 1'b0, 0, 1'b0);
    prot = 5'h00;
    run(8'h20, 24'h001000, 1, 1'b0, 0, 1'b0);
    run(8'hd8, 24'h021000, 0, 1'b0, 4, 1'b0);
    final_report();
  end
endmodule
